// file: rtl/ebpt_params.svh
// constants and field layout of the eight-bit pwm timer
`ifndef EBPT_PARAMS_SVH
`define EBPT_PARAMS_SVH

`define EBPT_ADDR_CTRL 8'h00
`define EBPT_ADDR_PERIOD 8'h04
`define EBPT_ADDR_DUTY 8'h08
`define EBPT_ADDR_STATUS 8'h0c
`define EBPT_ADDR_IRQ_STAT 8'h10
`define EBPT_ADDR_IRQ_MASK 8'h14

`define EBPT_CTRL_EN_BIT 0
`define EBPT_CTRL_OE_BIT 1
`define EBPT_CTRL_LEV_BIT 2
`define EBPT_CTRL_MODE_LSB 4
`define EBPT_CTRL_CKS_LSB 8
`define EBPT_CTRL_MASK 32'h0000_0737
`define EBPT_CTRL_RESET 32'h0000_0000

`define EBPT_CMP_RESET 8'h00
`define EBPT_CNT_ZERO 8'h00

`define EBPT_IRQ_MATCH_BIT 0
`define EBPT_IRQ_DUTY_BIT 1
`define EBPT_IRQ_XFER_BIT 2
`define EBPT_IRQ_RESET 3'h0

`define EBPT_STAT_OUT_BIT 8
`define EBPT_STAT_SEL_BIT 9
`define EBPT_STAT_PEND_BIT 10

`define EBPT_MIN_XFER_TICKS 2'h3

`define EBPT_DIV_MASK_2 6'h01
`define EBPT_DIV_MASK_4 6'h03
`define EBPT_DIV_MASK_16 6'h0f
`define EBPT_DIV_MASK_64 6'h3f

`endif

// file: rtl/ebpt_pkg.sv
// types shared by the eight-bit pwm timer
package ebpt_pkg;

  typedef enum logic [1:0] {
    EBPT_MODE_INTERVAL = 2'h0,
    EBPT_MODE_CARRIER = 2'h1,
    EBPT_MODE_PWM = 2'h2,
    EBPT_MODE_BAD = 2'h3
  } ebpt_mode_type;

  typedef enum logic [1:0] {
    EBPT_ST_IDLE = 2'h0,
    EBPT_ST_PERIOD = 2'h1,
    EBPT_ST_DUTY = 2'h3
  } ebpt_state_type;

  typedef enum logic [2:0] {
    EBPT_CKS_DIV1 = 3'h0,
    EBPT_CKS_DIV2 = 3'h1,
    EBPT_CKS_DIV4 = 3'h2,
    EBPT_CKS_DIV16 = 3'h3,
    EBPT_CKS_DIV64 = 3'h4,
    EBPT_CKS_SUB = 3'h5
  } ebpt_cks_type;

endpackage

// file: rtl/ebpt_prescaler.sv
// count clock tick generator with selectable division
`timescale 1ns/100ps
`include "ebpt_params.svh"

module ebpt_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire ebpt_pkg::ebpt_cks_type sel,
  input wire logic sub_tick,
  output logic tick
);

  logic [5:0] div_reg;
  logic [5:0] div_next;
  logic [5:0] div_mask;
  logic div_hit;

  // restarting the divider on stop gives a full first count clock after start
  assign div_next = run ? div_reg + 6'h01 : 6'h00;
  assign div_mask = (sel == ebpt_pkg::EBPT_CKS_DIV2) ? `EBPT_DIV_MASK_2 :
                    (sel == ebpt_pkg::EBPT_CKS_DIV4) ? `EBPT_DIV_MASK_4 :
                    (sel == ebpt_pkg::EBPT_CKS_DIV16) ? `EBPT_DIV_MASK_16 :
                    `EBPT_DIV_MASK_64;
  assign div_hit = (div_reg & div_mask) == div_mask;

  always_comb begin
    case (sel)
      ebpt_pkg::EBPT_CKS_DIV1: tick = run;
      ebpt_pkg::EBPT_CKS_DIV2,
      ebpt_pkg::EBPT_CKS_DIV4,
      ebpt_pkg::EBPT_CKS_DIV16,
      ebpt_pkg::EBPT_CKS_DIV64: tick = run & div_hit;
      ebpt_pkg::EBPT_CKS_SUB: tick = run & sub_tick;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 6'h00;
    end else if (ce) begin
      div_reg <= div_next;
    end
  end

endmodule

// file: rtl/ebpt_timer.sv
// eight-bit pwm / interval / carrier timer with apb register access
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ebpt_params.svh"

module ebpt_timer (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SUB_TICK,
  input wire logic CARRIER_GATE,
  output logic TIMER_OUT,
  output logic MATCH_INT,
  output logic IRQ
);

  function automatic logic [2:0] sticky(input logic [2:0] cur, input logic [2:0] set,
                                        input logic [2:0] clr);
    sticky = (cur & ~clr) | set;
  endfunction

  function automatic logic [31:0] pad8(input logic [7:0] v);
    pad8 = {24'h000000, v};
  endfunction

  logic [31:0] ctrl_reg;
  logic [7:0] period_reg;
  logic [7:0] duty_act_reg;
  logic [7:0] duty_buf_reg;
  logic duty_pend_reg;
  logic [1:0] duty_age_reg;
  logic [7:0] count_reg;
  ebpt_pkg::ebpt_state_type state_reg;
  logic wave_reg;
  logic out_reg;
  logic match_int_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] rdata_reg;

  logic [31:0] ctrl_next;
  logic [7:0] period_next;
  logic [7:0] duty_act_next;
  logic [7:0] duty_buf_next;
  logic duty_pend_next;
  logic [1:0] duty_age_next;
  logic [7:0] count_next;
  ebpt_pkg::ebpt_state_type state_next;
  logic wave_next;
  logic out_next;
  logic match_int_next;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_next;
  logic [31:0] rdata_next;

  // bus decode
  wire acc = PSEL & PENABLE & CE;
  wire setup = PSEL & ~PENABLE & CE;
  wire sel_ctrl = PADDR == `EBPT_ADDR_CTRL;
  wire sel_period = PADDR == `EBPT_ADDR_PERIOD;
  wire sel_duty = PADDR == `EBPT_ADDR_DUTY;
  wire sel_status = PADDR == `EBPT_ADDR_STATUS;
  wire sel_istat = PADDR == `EBPT_ADDR_IRQ_STAT;
  wire sel_imask = PADDR == `EBPT_ADDR_IRQ_MASK;
  wire mapped = sel_ctrl | sel_period | sel_duty | sel_status | sel_istat | sel_imask;
  wire wr = acc & PWRITE & mapped;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_period = wr & sel_period;
  wire wr_duty = wr & sel_duty;
  wire wr_istat = wr & sel_istat;
  wire wr_imask = wr & sel_imask;

  // control fields
  wire en_bit = ctrl_reg[`EBPT_CTRL_EN_BIT];
  wire oe_bit = ctrl_reg[`EBPT_CTRL_OE_BIT];
  wire lev_bit = ctrl_reg[`EBPT_CTRL_LEV_BIT];
  ebpt_pkg::ebpt_mode_type mode;
  ebpt_pkg::ebpt_cks_type cks;
  assign mode = ebpt_pkg::ebpt_mode_type'(ctrl_reg[`EBPT_CTRL_MODE_LSB +: 2]);
  assign cks = ebpt_pkg::ebpt_cks_type'(ctrl_reg[`EBPT_CTRL_CKS_LSB +: 3]);

  // the prohibited mode code simply keeps the timer stopped
  wire mode_pwm = mode == ebpt_pkg::EBPT_MODE_PWM;
  wire mode_car = mode == ebpt_pkg::EBPT_MODE_CARRIER;
  wire mode_int = mode == ebpt_pkg::EBPT_MODE_INTERVAL;
  wire run = en_bit & (mode_pwm | mode_car | mode_int);

  logic tick;

  ebpt_prescaler u_ebpt_prescaler (
    .clk(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .run(run),
    .sel(cks),
    .sub_tick(SUB_TICK),
    .tick(tick)
  );

  // compare engine
  wire on_duty = state_reg == ebpt_pkg::EBPT_ST_DUTY;
  wire counting = run & (state_reg != ebpt_pkg::EBPT_ST_IDLE);
  wire [7:0] cmp_val = on_duty ? duty_act_reg : period_reg;
  wire hit = counting & tick & (count_reg == cmp_val);
  wire hit_period = hit & ~on_duty;
  wire hit_duty = hit & on_duty;
  // pwm duty match keeps counting, every other match restarts the count
  wire clr_cnt = hit_period | (hit_duty & mode_car);
  wire irq_evt = hit_period | (hit_duty & mode_car);
  wire swap = hit & (mode_pwm | mode_car);
  wire xfer = hit_duty & duty_pend_reg & (duty_age_reg == `EBPT_MIN_XFER_TICKS);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    wave_next = wave_reg;
    if (!run) begin
      state_next = ebpt_pkg::EBPT_ST_IDLE;
      count_next = `EBPT_CNT_ZERO;
      wave_next = lev_bit;
    end else begin
      case (state_reg)
        ebpt_pkg::EBPT_ST_IDLE: begin
          state_next = ebpt_pkg::EBPT_ST_PERIOD;
          count_next = `EBPT_CNT_ZERO;
          wave_next = lev_bit;
        end
        ebpt_pkg::EBPT_ST_PERIOD,
        ebpt_pkg::EBPT_ST_DUTY: begin
          if (tick) begin
            count_next = clr_cnt ? `EBPT_CNT_ZERO : count_reg + 8'h01;
          end
          if (hit) begin
            wave_next = ~wave_reg;
          end
          if (swap) begin
            state_next = on_duty ? ebpt_pkg::EBPT_ST_PERIOD : ebpt_pkg::EBPT_ST_DUTY;
          end
        end
        default: begin
          state_next = ebpt_pkg::EBPT_ST_IDLE;
          count_next = `EBPT_CNT_ZERO;
          wave_next = lev_bit;
        end
      endcase
    end
  end

  // duty buffer: a write while counting waits for the old value's match
  always_comb begin
    duty_act_next = duty_act_reg;
    duty_buf_next = duty_buf_reg;
    duty_pend_next = duty_pend_reg;
    duty_age_next = duty_age_reg;
    if (xfer) begin
      duty_act_next = duty_buf_reg;
      duty_pend_next = 1'b0;
    end else if (duty_pend_reg & tick & (duty_age_reg != `EBPT_MIN_XFER_TICKS)) begin
      duty_age_next = duty_age_reg + 2'h1;
    end
    if (wr_duty) begin
      duty_buf_next = PWDATA[7:0];
      if (counting) begin
        duty_pend_next = 1'b1;
        duty_age_next = 2'h0;
      end else begin
        duty_act_next = PWDATA[7:0];
        duty_pend_next = 1'b0;
        duty_age_next = 2'h0;
      end
    end
  end

  // pin level: disabled output and gated-off carrier fall back to fixed levels
  assign out_next = ~oe_bit ? lev_bit :
                    (mode_car & run & ~CARRIER_GATE) ? 1'b0 :
                    wave_next;

  assign match_int_next = irq_evt;

  // registers
  assign ctrl_next = wr_ctrl ? (PWDATA & `EBPT_CTRL_MASK) : ctrl_reg;
  // period writes are taken even while counting; keeping them out is up to software
  assign period_next = wr_period ? PWDATA[7:0] : period_reg;
  wire [2:0] irq_set = {xfer, hit_duty, irq_evt};
  wire [2:0] irq_clr = wr_istat ? PWDATA[2:0] : 3'h0;
  assign irq_stat_next = sticky(irq_stat_reg, irq_set, irq_clr);
  assign irq_mask_next = wr_imask ? PWDATA[2:0] : irq_mask_reg;

  wire [31:0] status_word = {21'h000000, duty_pend_reg, on_duty, out_reg, count_reg};
  assign rdata_next = sel_ctrl ? ctrl_reg :
                      sel_period ? pad8(period_reg) :
                      sel_duty ? pad8(duty_buf_reg) :
                      sel_status ? status_word :
                      sel_istat ? {29'h00000000, irq_stat_reg} :
                      sel_imask ? {29'h00000000, irq_mask_reg} :
                      32'h00000000;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl_reg <= `EBPT_CTRL_RESET;
      period_reg <= `EBPT_CMP_RESET;
      duty_act_reg <= `EBPT_CMP_RESET;
      duty_buf_reg <= `EBPT_CMP_RESET;
      duty_pend_reg <= 1'b0;
      duty_age_reg <= 2'h0;
    end else if (CE) begin
      ctrl_reg <= ctrl_next;
      period_reg <= period_next;
      duty_act_reg <= duty_act_next;
      duty_buf_reg <= duty_buf_next;
      duty_pend_reg <= duty_pend_next;
      duty_age_reg <= duty_age_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg <= ebpt_pkg::EBPT_ST_IDLE;
      count_reg <= `EBPT_CNT_ZERO;
      wave_reg <= 1'b0;
      out_reg <= 1'b0;
      match_int_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      count_reg <= count_next;
      wave_reg <= wave_next;
      out_reg <= out_next;
      match_int_reg <= match_int_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      irq_stat_reg <= `EBPT_IRQ_RESET;
      irq_mask_reg <= `EBPT_IRQ_RESET;
      rdata_reg <= 32'h00000000;
    end else if (CE) begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      if (setup) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // bus answers; a frozen block holds off the master instead of losing writes
  assign PREADY = CE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = rdata_reg;

  assign TIMER_OUT = out_reg;
  assign MATCH_INT = match_int_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

endmodule

// file: dv/ebpt_timer_props.sv
// port-level assertions for the eight-bit pwm timer
`timescale 1ns/100ps
`include "ebpt_params.svh"
module ebpt_timer_props (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_OUT,
  input wire logic MATCH_INT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE && PREADY;
  wire mapped = PADDR <= `EBPT_ADDR_IRQ_MASK && PADDR[1:0] == 2'h0;
  wire cmp_rd = acc && !PWRITE && (PADDR == `EBPT_ADDR_PERIOD || PADDR == `EBPT_ADDR_DUTY);
  sequence ctrl_wr(logic en);
    acc && PWRITE && PADDR == `EBPT_ADDR_CTRL && PWDATA[0] == en;
  endsequence
  // default level needs two edges: register update, then pin update
  AST_STOP_DEFAULT: assert property (ctrl_wr(1'b0) |-> ##2
    (TIMER_OUT == $past(PWDATA[2], 2) && !MATCH_INT)) else $error("stop level wrong");
  // carrier mode left out: a low gate forces the pin low
  AST_START_DEFAULT: assert property (ctrl_wr(1'b1) ##0 !PWDATA[4] |-> ##2
    TIMER_OUT == $past(PWDATA[2], 2)) else $error("start level wrong");
  AST_MATCH_ONE_CYCLE: assert property (MATCH_INT |=> !MATCH_INT)
    else $error("match pulse too long");
  AST_READY_CE: assert property (PREADY == CE) else $error("ready not following enable");
  AST_UNMAPPED_ERR: assert property (PSEL && PENABLE && !mapped |-> PSLVERR)
    else $error("unmapped access not flagged");
  AST_MAPPED_OK: assert property (PSEL && PENABLE && mapped |-> !PSLVERR)
    else $error("mapped access flagged");
  AST_CMP_UPPER_ZERO: assert property (cmp_rd |-> PRDATA[31:8] == 24'h0)
    else $error("compare upper bits set");
  AST_MASK_OFF_IRQ: assert property (acc && PWRITE && PADDR == `EBPT_ADDR_IRQ_MASK
    && PWDATA[2:0] == 3'h0 |=> !IRQ) else $error("masked irq high");
endmodule

bind ebpt_timer ebpt_timer_props u_ebpt_timer_props (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_OUT(TIMER_OUT),
  .MATCH_INT(MATCH_INT), .IRQ(IRQ));

// file: dv/tb_ebpt_timer.sv
// self-checking bench for the eight-bit pwm timer
`timescale 1ns/100ps
`include "ebpt_params.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module tb_ebpt_timer;
  logic clock, rst_n, ce, psel, penable, pwrite, sub_tick, gate, er;
  logic pready, pslverr, tout, mint, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch, comparisons, hi, lo, mi;
  // period 3, duty 1: interval, carrier, then pwm at every divided count clock
  logic [31:0] cv [7] = '{32'h003, 32'h013, 32'h023, 32'h123, 32'h223, 32'h323, 32'h423};
  int eh [7] = '{4, 2, 2, 4, 8, 32, 128};
  int el [7] = '{4, 4, 2, 4, 8, 32, 128};
  // match pulses in one full period: pwm duty matches raise none
  int em [7] = '{2, 2, 1, 1, 1, 1, 1};
  ebpt_timer u_ebpt_timer (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SUB_TICK(sub_tick), .CARRIER_GATE(gate),
    .TIMER_OUT(tout), .MATCH_INT(mint), .IRQ(irq));
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // widths of one high phase and the low phase after it, in system clocks
  task automatic meas();
    int t;
    t = 0;
    @(posedge clock);
    while (tout !== 1'b0 && t < 600) begin @(posedge clock); t++; end
    while (tout !== 1'b1 && t < 600) begin @(posedge clock); t++; end
    hi = 0;
    lo = 0;
    mi = 0;
    while (tout === 1'b1 && hi < 600) begin
      @(posedge clock);
      hi++;
      if (mint === 1'b1) mi++;
    end
    while (tout === 1'b0 && lo < 600) begin
      @(posedge clock);
      lo++;
      if (mint === 1'b1) mi++;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // whole run is about a thousand clocks; this leaves a wide margin
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, sub_tick, paddr, pwdata} = '0;
    {ce, gate, rst_n} = 3'b110;
    repeat (6) @(posedge clock);
    rst_n <= 1;
    apb(0, `EBPT_ADDR_CTRL, 0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(0, 8'h18, 0);
    `CHK("unmapped err", 1'b1, er)
    @(posedge clock);
    ce <= 0;
    @(posedge clock);
    @(posedge clock);
    `CHK("ready frozen", 1'b0, pready)
    ce <= 1;
    apb(1, `EBPT_ADDR_PERIOD, 3);
    apb(1, `EBPT_ADDR_DUTY, 1);
    apb(0, `EBPT_ADDR_DUTY, 0);
    `CHK("duty readback", 32'h1, rd)
    for (int i = 0; i < 7; i++) begin
      apb(1, `EBPT_ADDR_CTRL, cv[i]);
      meas();
      `CHK("high width", eh[i], hi)
      `CHK("low width", el[i], lo)
      `CHK("match pulses", em[i], mi)
      apb(1, `EBPT_ADDR_CTRL, 32'h2);
      apb(1, `EBPT_ADDR_DUTY, 1);
      `CHK("stopped pin", 1'b0, tout)
      `CHK("stopped int", 1'b0, mint)
    end
    apb(1, `EBPT_ADDR_PERIOD, 5);
    apb(1, `EBPT_ADDR_CTRL, 32'h027);
    repeat (2) @(posedge clock);
    `CHK("start high", 1'b1, tout)
    meas();
    `CHK("inactive width", 4, hi)
    `CHK("active width", 2, lo)
    // changed duty only lands at a later duty match, so measure twice
    apb(1, `EBPT_ADDR_DUTY, 3);
    meas();
    // first duty match comes too soon after the write, so the old value stays
    `CHK("held inactive", 4, hi)
    `CHK("held active", 2, lo)
    meas();
    `CHK("new inactive", 2, hi)
    `CHK("new active", 4, lo)
    apb(1, `EBPT_ADDR_CTRL, 32'h6);
    repeat (2) @(posedge clock);
    `CHK("stop high", 1'b1, tout)
    apb(1, `EBPT_ADDR_IRQ_MASK, 0);
    @(posedge clock);
    `CHK("irq masked", 1'b0, irq)
    apb(0, `EBPT_ADDR_IRQ_STAT, 0);
    `CHK("match status", 1'b1, rd[`EBPT_IRQ_MATCH_BIT])
    apb(1, `EBPT_ADDR_IRQ_MASK, 1);
    @(posedge clock);
    `CHK("irq raised", 1'b1, irq)
    apb(1, `EBPT_ADDR_IRQ_STAT, 7);
    apb(0, `EBPT_ADDR_IRQ_STAT, 0);
    `CHK("status cleared", 32'h0, rd)
    `CHK("irq cleared", 1'b0, irq)
    apb(1, `EBPT_ADDR_CTRL, 32'h033);
    repeat (10) @(posedge clock);
    apb(0, `EBPT_ADDR_STATUS, 0);
    `CHK("bad mode count", 8'h00, rd[7:0])
    // default level high, and the free carrier would be high at the check
    gate <= 0;
    apb(1, `EBPT_ADDR_DUTY, 3);
    apb(1, `EBPT_ADDR_CTRL, 32'h017);
    repeat (16) @(posedge clock);
    `CHK("gated carrier", 1'b0, tout)
    gate <= 1;
    apb(1, `EBPT_ADDR_CTRL, 32'h2);
    apb(1, `EBPT_ADDR_DUTY, 3);
    apb(1, `EBPT_ADDR_CTRL, 32'h523);
    @(posedge clock);
    repeat (3) begin
      sub_tick <= 1;
      @(posedge clock);
      sub_tick <= 0;
      @(posedge clock);
    end
    apb(0, `EBPT_ADDR_STATUS, 0);
    `CHK("sub ticks", 8'h03, rd[7:0])
    apb(1, `EBPT_ADDR_CTRL, 32'h2);
    finish_test();
  end
endmodule
